// ---- core/chg_cfg_pkg.sv ----
// Constants, tables and types for the charger tracking and thermal
// configuration register bank.
// Assumes a single 125 MHz clock and a thermistor ratio given in
// thousandths of a percent of the bias supply.
package chg_cfg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] ADDR_REG_RESET = 8'h19;
  localparam logic [ADDR_W-1:0] ADDR_TRACK     = 8'h1a;
  localparam logic [ADDR_W-1:0] ADDR_THRESH    = 8'h1b;
  localparam logic [ADDR_W-1:0] ADDR_REGION    = 8'h1c;
  localparam logic [ADDR_W-1:0] ADDR_REV_TH    = 8'h1d;
  localparam logic [ADDR_W-1:0] ADDR_CONV_CFG  = 8'h2a;

  localparam logic [DATA_W-1:0] RST_TRACK  = 8'h20;
  localparam logic [DATA_W-1:0] RST_THRESH = 8'h96;
  localparam logic [DATA_W-1:0] RST_REGION = 8'h57;
  localparam logic [DATA_W-1:0] RST_REV_TH = 8'h40;

  // Bits that a host write may change; the rest hold their reset value, except the force bit of the tracking register.
  localparam logic [DATA_W-1:0] MASK_TRACK  = 8'h07;
  localparam logic [DATA_W-1:0] MASK_THRESH = 8'hff;
  localparam logic [DATA_W-1:0] MASK_REGION = 8'h7f;
  localparam logic [DATA_W-1:0] MASK_REV_TH = 8'he0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int REGRST_BIT = 7;
  localparam int FORCE_BIT  = 7;
  localparam int INTV_LSB   = 1;
  localparam int TRK_EN_BIT = 0;
  localparam int HOT_LSB    = 6;
  localparam int WARM_LSB   = 4;
  localparam int COOL_LSB   = 2;
  localparam int COLD_LSB   = 0;
  localparam int VSEL_LSB   = 5;
  localparam int ISETH_BIT  = 4;
  localparam int ISETC_LSB  = 2;
  localparam int PROF_BIT   = 1;
  localparam int TSEN_BIT   = 0;

  // ----------------------------------------------------------------
  // Thermistor thresholds, thousandths of a percent
  // ----------------------------------------------------------------
  localparam int RATIO_W = 17;
  typedef logic [RATIO_W-1:0] ratio_type;
  localparam ratio_type HOT_TAB  [0:3] = '{17'd41200, 17'd37700,
                                           17'd34375, 17'd31250};
  localparam ratio_type WARM_TAB [0:3] = '{17'd48400, 17'd44800,
                                           17'd41200, 17'd37700};
  localparam ratio_type COOL_TAB [0:3] = '{17'd71100, 17'd68400,
                                           17'd65500, 17'd62400};
  localparam ratio_type COLD_TAB [0:3] = '{17'd77150, 17'd75320,
                                           17'd73250, 17'd71100};

  // ----------------------------------------------------------------
  // Charge targets: voltage in tenths of a percent, current in percent
  // ----------------------------------------------------------------
  localparam int VOLT_W = 10;
  localparam int CUR_W  = 7;
  localparam logic [VOLT_W-1:0] VOLT_TAB [0:3] = '{10'd0, 10'd943,
                                                   10'd976, 10'd1000};
  localparam logic [VOLT_W-1:0] VOLT_FULL = 10'd1000;
  localparam logic [CUR_W-1:0]  COOL_CUR_TAB [0:3] = '{7'd0, 7'd20,
                                                       7'd40, 7'd100};
  localparam logic [CUR_W-1:0]  WARM_CUR_LO = 7'd40;
  localparam logic [CUR_W-1:0]  CUR_FULL    = 7'd100;
  localparam logic [1:0]        SEL_SUSPEND = 2'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 8;
  localparam int SEC_NS         = 1000000000;
  localparam int CYCLES_PER_SEC = SEC_NS / CLK_PERIOD_NS;
  localparam int SEC_PER_MIN    = 60;
  localparam int SEC_W          = 11;
  localparam int INTV_MIN [0:3] = '{3, 10, 15, 20};

  function automatic logic [SEC_W-1:0] interval_sec(input logic [1:0] c);
    interval_sec = SEC_W'(INTV_MIN[c] * SEC_PER_MIN);
  endfunction

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ZONE_NORMAL = 5'b00001,
    ZONE_COLD   = 5'b00010,
    ZONE_COOL   = 5'b00100,
    ZONE_WARM   = 5'b01000,
    ZONE_HOT    = 5'b10000
  } zone_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SWEEP = 2'b10
  } sweep_state_type;

endpackage

// ---- core/ts_zone_classifier.sv ----
// Thermistor region classifier, purely combinational.
// Assumes the ratio and the threshold codes are on the same clock as
// the register bank that consumes the result.
`timescale 1ns/1ps

module ts_zone_classifier
  import chg_cfg_pkg::*;
(
  input  wire chg_cfg_pkg::ratio_type ratio,     // Thermistor ratio
  input  wire logic [1:0]             hot_sel,   // Hot limit code
  input  wire logic [1:0]             warm_sel,  // Warm limit code
  input  wire logic [1:0]             cool_sel,  // Cool limit code
  input  wire logic [1:0]             cold_sel,  // Cold limit code
  input  wire logic                   prof_en,   // Four-zone profile on
  input  wire logic                   ts_en,     // Thermistor used
  output chg_cfg_pkg::zone_type       zone       // Region found
);

  // A lower ratio means a hotter battery, so hot wins over warm and
  // cold over cool when limits overlap.
  always_comb begin
    zone = ZONE_NORMAL;
    if (!ts_en) begin
      zone = ZONE_NORMAL;
    end else if (ratio <= HOT_TAB[hot_sel]) begin
      zone = ZONE_HOT;
    end else if (ratio >= COLD_TAB[cold_sel]) begin
      zone = ZONE_COLD;
    end else if (prof_en && ratio <= WARM_TAB[warm_sel]) begin
      zone = ZONE_WARM;
    end else if (prof_en && ratio >= COOL_TAB[cool_sel]) begin
      zone = ZONE_COOL;
    end
  end

endmodule

// ---- core/charger_max_power_tracking_thermal_cfg_regs.sv ----
// Configuration register bank for panel power tracking and battery
// thermistor supervision, with the sweep scheduler and region outputs.
// Assumes the serial bus engine presents byte accesses on the same
// clock, and that the tracking engine pulses sweep_done.
`timescale 1ns/1ps

// Behaviour
// - Writing one to the force-sweep bit starts a full sweep and restarts the timers; the bit clears when the sweep finishes.
// - The sweep interval code selects 3, 10, 15 or 20 minutes between automatic sweeps and resets to code zero.
// - Bit 0 enables tracking, and while it is set host writes to the converter configuration register are dropped.
// - The hot limit code selects 41.2, 37.7, 34.375 or 31.25 percent and resets to code two.
// - The warm limit code selects 48.4, 44.8, 41.2 or 37.7 percent and resets to code one.
// - The cool limit code selects 71.1, 68.4, 65.5 or 62.4 percent and resets to code one.
// - The cold limit code selects 77.15, 75.32, 73.25 or 71.1 percent and resets to code two.
// - In the warm region the voltage code suspends charge or gives 94.3, 97.6 or 100 percent, resetting to code two.
// - In the warm region one bit gives 40 or 100 percent of the charge current and resets to one.
// - In the cool region the current code suspends charge or gives 20, 40 or 100 percent, resetting to code one.
// - With the profile bit clear only cold and hot act; with it set all four regions act; it resets to set.
// - With the thermistor bit clear the thermistor is ignored in charge and discharge; it resets to set.
// - Writing one to the register-reset bit returns every register to default and the bit then clears.
module charger_max_power_tracking_thermal_cfg_regs #(
  parameter int SEC_CYCLES = chg_cfg_pkg::CYCLES_PER_SEC
) (
  input  wire logic                           ref_clk,     // Clock
  input  wire logic                           rst,         // Async reset
  input  wire logic [chg_cfg_pkg::ADDR_W-1:0] reg_addr,    // Byte address
  input  wire logic [chg_cfg_pkg::DATA_W-1:0] reg_wdata,   // Write data
  input  wire logic                           reg_wr,      // Write strobe
  input  wire logic                           reg_rd,      // Read strobe
  output logic [chg_cfg_pkg::DATA_W-1:0]      reg_rdata,   // Read data
  output logic                                reg_rvalid,  // Read answer
  input  wire logic                           sweep_done,  // Sweep ended
  input  wire chg_cfg_pkg::ratio_type         ts_ratio,    // Thermistor
  output logic                                sweep_start, // Sweep begins
  output logic                                sweep_busy,  // Sweeping
  output logic                                tracking_enable, // Tracking
  output logic                                thermistor_enable, // TS on
  output logic                                conv_cfg_we, // Conv write
  output logic [chg_cfg_pkg::DATA_W-1:0]      conv_cfg_wdata, // Its data
  output chg_cfg_pkg::zone_type               thermal_zone, // Region
  output logic                                charge_suspend, // Stop
  output logic [chg_cfg_pkg::VOLT_W-1:0]      charge_voltage_pct, // 0.1%
  output logic [chg_cfg_pkg::CUR_W-1:0]       charge_current_pct  // 1%
);
  import chg_cfg_pkg::*;

  // ----------------------------------------------------------------
  // Register storage and host access
  // ----------------------------------------------------------------
  localparam int PS_W = $clog2(SEC_CYCLES + 1);
  localparam logic [PS_W-1:0] PS_LAST = PS_W'(SEC_CYCLES - 1);

  logic [DATA_W-1:0] track_reg;
  logic [DATA_W-1:0] thresh_reg;
  logic [DATA_W-1:0] region_reg;
  logic [DATA_W-1:0] rev_th_reg;
  logic              reg_reset_reg;
  sweep_state_type   state_reg;
  logic [PS_W-1:0]   presc_reg;
  logic [SEC_W-1:0]  sec_reg;
  zone_type          zone_next;

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                              input logic [DATA_W-1:0] wd,
                                              input logic [DATA_W-1:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction

  logic wr_track;
  logic force_set;
  logic force_clr;
  logic auto_due;
  assign wr_track  = reg_wr && (reg_addr == ADDR_TRACK);
  assign force_set = wr_track && reg_wdata[FORCE_BIT];
  assign force_clr = (state_reg == ST_SWEEP) && sweep_done;
  assign auto_due  = track_reg[TRK_EN_BIT] &&
                     (sec_reg >= interval_sec(track_reg[INTV_LSB +: 2]));

  // The reset bit stays set for one cycle, then returns every register to its reset value.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_reset_reg <= 1'b0;
    end else if (reg_reset_reg) begin
      reg_reset_reg <= 1'b0;
    end else if (reg_wr && reg_addr == ADDR_REG_RESET) begin
      reg_reset_reg <= reg_wdata[REGRST_BIT];
    end
  end

  // A new force request in the cycle a sweep ends keeps the bit set.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      track_reg <= RST_TRACK;
    end else if (reg_reset_reg) begin
      track_reg <= RST_TRACK;
    end else begin
      if (wr_track) begin
        track_reg <= merge(track_reg, reg_wdata, MASK_TRACK);
      end
      if (force_set) begin
        track_reg[FORCE_BIT] <= 1'b1;
      end else if (force_clr) begin
        track_reg[FORCE_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      thresh_reg <= RST_THRESH;
      region_reg <= RST_REGION;
      rev_th_reg <= RST_REV_TH;
    end else if (reg_reset_reg) begin
      thresh_reg <= RST_THRESH;
      region_reg <= RST_REGION;
      rev_th_reg <= RST_REV_TH;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_THRESH) begin
        thresh_reg <= merge(thresh_reg, reg_wdata, MASK_THRESH);
      end
      if (reg_addr == ADDR_REGION) begin
        region_reg <= merge(region_reg, reg_wdata, MASK_REGION);
      end
      if (reg_addr == ADDR_REV_TH) begin
        rev_th_reg <= merge(rev_th_reg, reg_wdata, MASK_REV_TH);
      end
    end
  end

  // Unmapped addresses answer zero.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rvalid <= 1'b0;
      reg_rdata  <= '0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        unique case (reg_addr)
          ADDR_REG_RESET: reg_rdata <= {reg_reset_reg, 7'h00};
          ADDR_TRACK:     reg_rdata <= track_reg;
          ADDR_THRESH:    reg_rdata <= thresh_reg;
          ADDR_REGION:    reg_rdata <= region_reg;
          ADDR_REV_TH:    reg_rdata <= rev_th_reg;
          default:        reg_rdata <= '0;
        endcase
      end
    end
  end

  // Converter writes pass only while software owns the converter.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      conv_cfg_we    <= 1'b0;
      conv_cfg_wdata <= '0;
    end else begin
      conv_cfg_we <= reg_wr && (reg_addr == ADDR_CONV_CFG) &&
                     !track_reg[TRK_EN_BIT];
      if (reg_wr && reg_addr == ADDR_CONV_CFG) begin
        conv_cfg_wdata <= reg_wdata;
      end
    end
  end

  assign tracking_enable   = track_reg[TRK_EN_BIT];
  assign thermistor_enable = region_reg[TSEN_BIT];
  assign sweep_busy        = (state_reg == ST_SWEEP);

  // ----------------------------------------------------------------
  // Sweep scheduler
  // ----------------------------------------------------------------
  // Timers are held at zero while disabled or sweeping, so an interval
  // is measured from the end of the previous sweep.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      presc_reg <= '0;
      sec_reg   <= '0;
    end else if (reg_reset_reg || force_set || !track_reg[TRK_EN_BIT] ||
                 state_reg == ST_SWEEP) begin
      presc_reg <= '0;
      sec_reg   <= '0;
    end else if (presc_reg == PS_LAST) begin
      presc_reg <= '0;
      sec_reg   <= sec_reg + SEC_W'(1);
    end else begin
      presc_reg <= presc_reg + PS_W'(1);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg   <= ST_IDLE;
      sweep_start <= 1'b0;
    end else if (reg_reset_reg) begin
      state_reg   <= ST_IDLE;
      sweep_start <= 1'b0;
    end else begin
      sweep_start <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (track_reg[FORCE_BIT] || auto_due) begin
            state_reg   <= ST_SWEEP;
            sweep_start <= 1'b1;
          end
        end
        ST_SWEEP: begin
          if (sweep_done) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Thermal region and charge targets
  // ----------------------------------------------------------------
  ts_zone_classifier u_classifier (
    .ratio    (ts_ratio),
    .hot_sel  (thresh_reg[HOT_LSB +: 2]),
    .warm_sel (thresh_reg[WARM_LSB +: 2]),
    .cool_sel (thresh_reg[COOL_LSB +: 2]),
    .cold_sel (thresh_reg[COLD_LSB +: 2]),
    .prof_en  (region_reg[PROF_BIT]),
    .ts_en    (region_reg[TSEN_BIT]),
    .zone     (zone_next)
  );

  logic [1:0] vsel;
  logic [1:0] isetc;
  assign vsel  = region_reg[VSEL_LSB +: 2];
  assign isetc = region_reg[ISETC_LSB +: 2];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      thermal_zone       <= ZONE_NORMAL;
      charge_suspend     <= 1'b0;
      charge_voltage_pct <= VOLT_FULL;
      charge_current_pct <= CUR_FULL;
    end else begin
      thermal_zone       <= zone_next;
      charge_suspend     <= 1'b0;
      charge_voltage_pct <= VOLT_FULL;
      charge_current_pct <= CUR_FULL;
      unique case (zone_next)
        ZONE_COLD, ZONE_HOT: charge_suspend <= 1'b1;
        ZONE_WARM: begin
          charge_voltage_pct <= VOLT_TAB[vsel];
          charge_suspend     <= (vsel == SEL_SUSPEND);
          charge_current_pct <= region_reg[ISETH_BIT] ? CUR_FULL
                                                      : WARM_CUR_LO;
        end
        ZONE_COOL: begin
          charge_current_pct <= COOL_CUR_TAB[isetc];
          charge_suspend     <= (isetc == SEL_SUSPEND);
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_force_clears: assert property (
    force_clr && !force_set && !reg_reset_reg |=> !track_reg[FORCE_BIT])
    else $error("force bit not cleared at sweep end");
  chk_force_starts: assert property (
    state_reg == ST_IDLE && track_reg[FORCE_BIT] && !reg_reset_reg
    |=> sweep_start && sweep_busy)
    else $error("forced sweep did not start");
  chk_conv_blocked: assert property (
    reg_wr && reg_addr == ADDR_CONV_CFG && tracking_enable
    |=> !conv_cfg_we)
    else $error("converter write passed while tracking");
  chk_conv_passes: assert property (
    reg_wr && reg_addr == ADDR_CONV_CFG && !tracking_enable
    |=> conv_cfg_we && conv_cfg_wdata == $past(reg_wdata))
    else $error("converter write lost while not tracking");
  chk_soft_reset: assert property (
    reg_wr && reg_addr == ADDR_REG_RESET && reg_wdata[REGRST_BIT] &&
    !reg_reset_reg
    |=> reg_reset_reg ##1 (!reg_reset_reg && thresh_reg == RST_THRESH &&
                           region_reg == RST_REGION &&
                           track_reg == RST_TRACK && !sweep_busy))
    else $error("register reset did not restore defaults");
  chk_ts_ignored: assert property (
    !region_reg[TSEN_BIT] |=> thermal_zone == ZONE_NORMAL &&
                              !charge_suspend)
    else $error("thermistor not ignored when disabled");
  chk_profile_off: assert property (
    !region_reg[PROF_BIT] |=> thermal_zone != ZONE_WARM &&
                              thermal_zone != ZONE_COOL)
    else $error("cool or warm region used with profile off");
  chk_hot_suspend: assert property (
    thermal_zone == ZONE_HOT || thermal_zone == ZONE_COLD
    |-> charge_suspend)
    else $error("charging not suspended outside limits");
  chk_warm_voltage: assert property (
    zone_next == ZONE_WARM |=> charge_voltage_pct == VOLT_TAB[$past(vsel)])
    else $error("warm voltage target wrong");
  // A forced sweep may still start while tracking is off.
  chk_auto_timer: assert property (
    !tracking_enable |=> sec_reg == '0 &&
                         (!sweep_start || $past(track_reg[FORCE_BIT])))
    else $error("interval timer ran while tracking off");

  cov_forced_sweep: cover property (force_set ##1 track_reg[FORCE_BIT]
                                    ##[1:20] sweep_done);
  cov_conv_block:   cover property (reg_wr && reg_addr == ADDR_CONV_CFG &&
                                    tracking_enable);
  cov_warm_zone:    cover property (thermal_zone == ZONE_WARM);
  cov_soft_reset:   cover property (reg_reset_reg);

endmodule

// ---- dv/host_model.sv ----
// Host side of the register port: single byte writes and reads.
// Assumes the bank answers a read with reg_rvalid one cycle later.
`timescale 1ns/1ps

module host_model (
  input  wire logic       ref_clk,   // Clock
  output logic [7:0]      reg_addr,  // Byte address
  output logic [7:0]      reg_wdata, // Write data
  output logic            reg_wr,    // Write strobe
  output logic            reg_rd,    // Read strobe
  input  wire logic [7:0] reg_rdata, // Read data
  input  wire logic       reg_rvalid // Read answer
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // Idle address and data show the inverse of the last value, so a bank
  // that samples them outside a strobe reads garbage, not a lucky match.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    d = 8'hxx;
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    repeat (3) begin
      @(posedge ref_clk);
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        break;
      end
    end
  endtask
endmodule

// ---- dv/charger_max_power_tracking_thermal_cfg_regs_tb.sv ----
// Self-checking bench for the tracking and thermal register bank.
// Assumes SEC_CYCLES of 1, so one interval minute is 60 clock cycles.
`timescale 1ns/1ps

module charger_max_power_tracking_thermal_cfg_regs_tb;
  import chg_cfg_pkg::*;
  typedef struct {
    logic [7:0] a, w, r;
    ratio_type t;
    zone_type z;
    logic [9:0] v;
    logic [6:0] c;
    logic s;
  } row_type;
  logic ref_clk, rst, wr, rd, rvalid, done, start, busy, trk, tsen;
  logic cwe, susp;
  logic [7:0] addr, wdata, rdata, cwd, d;
  ratio_type ts_ratio;
  zone_type zone;
  logic [9:0] volt;
  logic [6:0] cur;
  int bad_count, n_compared, n, e;
  row_type rows [15] = '{
    '{8'h1b, 8'h96, 8'h96, 30000, ZONE_HOT, 1000, 100, 1},
    '{8'h1b, 8'h96, 8'h96, 40000, ZONE_WARM, 976, 100, 0},
    '{8'h1c, 8'h17, 8'h17, 40000, ZONE_WARM, 0, 100, 1},
    '{8'h1c, 8'h67, 8'h67, 40000, ZONE_WARM, 1000, 40, 0},
    '{8'h1c, 8'h6f, 8'h6f, 70000, ZONE_COOL, 1000, 100, 0},
    '{8'h1c, 8'h6b, 8'h6b, 70000, ZONE_COOL, 1000, 40, 0},
    '{8'h1c, 8'h63, 8'h63, 70000, ZONE_COOL, 1000, 0, 1},
    '{8'h1c, 8'h65, 8'h65, 70000, ZONE_NORMAL, 1000, 100, 0},
    '{8'h1c, 8'h64, 8'h64, 30000, ZONE_NORMAL, 1000, 100, 0},
    '{8'h1c, 8'h57, 8'h57, 80000, ZONE_COLD, 1000, 100, 1},
    '{8'h1b, 8'hff, 8'hff, 33000, ZONE_WARM, 976, 100, 0},
    '{8'h1b, 8'h00, 8'h00, 76000, ZONE_COOL, 1000, 20, 0},
    '{8'h1d, 8'hff, 8'he0, 55000, ZONE_NORMAL, 1000, 100, 0},
    '{8'h1a, 8'h06, 8'h26, 55000, ZONE_NORMAL, 1000, 100, 0},
    '{8'h30, 8'h55, 8'h00, 55000, ZONE_NORMAL, 1000, 100, 0}};

  host_model h_u (.ref_clk(ref_clk), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rvalid));

  charger_max_power_tracking_thermal_cfg_regs #(.SEC_CYCLES(1)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .sweep_done(done), .ts_ratio(ts_ratio), .sweep_start(start),
    .sweep_busy(busy), .tracking_enable(trk), .thermistor_enable(tsen),
    .conv_cfg_we(cwe), .conv_cfg_wdata(cwd), .thermal_zone(zone),
    .charge_suspend(susp), .charge_voltage_pct(volt),
    .charge_current_pct(cur));

  task automatic chk(input string nm, input logic [16:0] ex, g);
    n_compared++;
    if (g !== ex) begin
      bad_count++;
      $display("wrong value %s exp %0h got %0h", nm, ex, g);
    end
  endtask

  task automatic stop_test;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Sweep end comes from the tracking engine, modelled here as a pulse.
  task automatic end_sweep;
    @(posedge ref_clk);
    done <= 1'b1;
    @(posedge ref_clk);
    done <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wait_start(input int lim);
    n = 0;
    while (start !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    stop_test();
  end

  initial begin
    rst = 1'b1;
    done = 1'b0;
    ts_ratio = 55000;
    bad_count = 0;
    n_compared = 0;
    repeat (8) @(posedge ref_clk);
    chk("trk_rst", 0, trk);
    chk("ts_rst", 1, tsen);
    rst <= 1'b0;
    $display("reset test done");
    foreach (rows[i]) begin
      h_u.wr(rows[i].a, rows[i].w);
      ts_ratio <= rows[i].t;
      h_u.rd(rows[i].a, d);
      chk("rdata", rows[i].r, d);
      chk("zone", rows[i].z, zone);
      chk("volt", rows[i].v, volt);
      chk("cur", rows[i].c, cur);
      chk("susp", rows[i].s, susp);
    end
    $display("row test done");
    h_u.wr(8'h2a, 8'h5a);
    #1 chk("conv_we", 1, cwe);
    chk("conv_data", 8'h5a, cwd);
    h_u.wr(8'h1a, 8'h01);
    h_u.wr(8'h2a, 8'ha5);
    #1 chk("conv_drop", 0, cwe);
    $display("converter test done");
    for (int k = 0; k < 4; k++) begin
      h_u.wr(8'h1a, 8'h00);
      h_u.wr(8'h1a, {5'h00, 2'(k), 1'b1});
      e = INTV_MIN[k] * 60;
      wait_start(1300);
      chk("interval", 1, n >= e - 2 && n <= e + 3);
      end_sweep();
    end
    $display("interval test done");
    h_u.wr(8'h1a, 8'h80);
    wait_start(8);
    chk("force_start", 1, n < 8);
    h_u.rd(8'h1a, d);
    chk("force_bit", 8'ha0, d);
    chk("busy", 1, busy);
    end_sweep();
    h_u.rd(8'h1a, d);
    chk("force_clr", 8'h20, d);
    chk("idle", 0, busy);
    $display("force test done");
    h_u.wr(8'h19, 8'h80);
    repeat (3) @(posedge ref_clk);
    h_u.rd(8'h1b, d);
    chk("soft_1b", 8'h96, d);
    h_u.rd(8'h1d, d);
    chk("soft_1d", 8'h40, d);
    h_u.rd(8'h19, d);
    chk("soft_19", 8'h00, d);
    $display("soft reset test done");
    h_u.wr(8'h1c, 8'h00);
    rst <= 1'b1;
    ts_ratio <= 30000;
    @(posedge ref_clk);
    chk("rst_zone", ZONE_NORMAL, zone);
    rst <= 1'b0;
    h_u.rd(8'h1c, d);
    chk("rst_1c", 8'h57, d);
    chk("rst_tsen", 1, tsen);
    chk("rst_hot", ZONE_HOT, zone);
    h_u.rd(8'h1a, d);
    chk("rst_1a", 8'h20, d);
    $display("mid reset test done");
    stop_test();
  end
endmodule
